// File: logic/sd_video_encoder_control.sv
// SD encoder control register bank with decoded controls and luma/chroma delays
`timescale 1ns/10ps
//  Operation
// RQ1: Colour bars on when control bit clear
// RQ2: Burst pattern on when control bit clear
// RQ3: Chroma removed when chroma bit set
// RQ4: PrPb swing code selects output level
// RQ5: Luma bit selects Y video/sync split
// RQ6: Component pedestal bit adds 7.5 IRE
// RQ7: Line length 720, or 710/702 pixels
// RQ8: Lock code with pin sets frequency lock
// RQ9: Counters follow timing or run freely
// RQ10: Burst position code sets burst delay
// RQ11: Gamma curve choice only when enabled
// RQ12: Double buffer holds writes in shadow
// RQ13: Chroma delay zero, four, eight clocks
// RQ14: Luma delay zero, two, four, six clocks
// RQ15: Undershoot clamp code selects limit
// RQ16: Luma floor bit selects minimum level
// RQ17: Subcarrier from 32-bit four-byte word
// RQ18: Four pedestal enable bytes, lines 17/25
// RQ19: Caption enables per even/odd field
// RQ20: Blanking data accepted when bit set
// RQ21: Two 16-bit extended caption words
// RQ22: Autodetect lets encoder find standard
// RQ23: Standard code NTSC, PAL BDGHI, M, N
// RQ24: All fields reset to default values
module sd_video_encoder_control
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    input  wire sd_enc_pkg::host_req_t   host_req,
    input  wire logic                    frame_update,
    input  wire logic                    subcarrier_lock_pin,
    input  wire logic [9:0]              luma_in,
    input  wire logic [9:0]              chroma_in,
    output logic      [7:0]              host_rdata,
    output logic                         host_rvalid,
    output sd_enc_pkg::control_t         control,
    output logic      [9:0]              luma_out,
    output logic      [9:0]              chroma_out
);
    typedef logic [sd_enc_pkg::REG_N-1:0][7:0] reg_array_t;

    typedef struct packed {
        reg_array_t           live;
        reg_array_t           shadow;
        logic [1:0]           lock_sync;
        logic [7:0]           rdata;
        logic                 rvalid;
        sd_enc_pkg::control_t ctrl;
    } bank_state_t;

    bank_state_t state;
    bank_state_t next_state;
    logic [3:0]  luma_tap;
    logic [3:0]  chroma_tap;

    // Address to array index; out of range gives an invalid flag
    function automatic logic [5:0] decode(input logic [15:0] addr);
        logic [15:0] off;
        off = addr - sd_enc_pkg::ADDR_FIRST;
        if (addr < sd_enc_pkg::ADDR_FIRST || addr > sd_enc_pkg::ADDR_LAST)
            return 6'h20;
        return {1'b0, off[4:0]};
    endfunction

    // Byte of a register by its address
    function automatic logic [7:0] pick(input reg_array_t r, input logic [15:0] addr);
        logic [5:0] i;
        i = decode(addr);
        return r[i[4:0]];
    endfunction

    // Reset image of the whole map
    function automatic reg_array_t reset_image();
        reg_array_t r;
        r = '0;
        r[decode(sd_enc_pkg::ADDR_OUTPUT_MODE_A)]  = sd_enc_pkg::RST_OUTPUT_MODE_A;
        r[decode(sd_enc_pkg::ADDR_LINE_TIMING)]    = sd_enc_pkg::RST_LINE_TIMING;
        r[decode(sd_enc_pkg::ADDR_LEVEL_CONTROL)]  = sd_enc_pkg::RST_LEVEL_CONTROL;
        r[decode(sd_enc_pkg::ADDR_COUNTER_SYNC)]   = sd_enc_pkg::RST_COUNTER_SYNC;
        r[decode(sd_enc_pkg::ADDR_LUMA_MIN_DELAY)] = sd_enc_pkg::RST_LUMA_MIN_DELAY;
        r[decode(sd_enc_pkg::ADDR_CAPTION_VBI)]    = sd_enc_pkg::RST_CAPTION_VBI;
        return r;
    endfunction

    // Register file, shadow path, read port and control decode
    always_comb
    begin
        logic [5:0]  widx;
        logic        shadow_on;
        logic        is_gamma_reg;
        reg_array_t  r;
        logic [1:0]  code;
        widx = decode(host_req.addr);
        r = '0;
        code = 2'b00;
        next_state = state;
        shadow_on = state.live[decode(sd_enc_pkg::ADDR_GAMMA_BUFFER)][sd_enc_pkg::B_SHADOW_ON];
        is_gamma_reg = (host_req.addr == sd_enc_pkg::ADDR_GAMMA_BUFFER);
        next_state.lock_sync = {state.lock_sync[0], subcarrier_lock_pin};
        next_state.rvalid = 1'b0;
        if (frame_update)
            next_state.live = state.shadow;                               // [RQ12]
        if (host_req.write && !widx[5])
        begin
            next_state.shadow[widx[4:0]] = host_req.wdata;
            if (!shadow_on || is_gamma_reg)
                next_state.live[widx[4:0]] = host_req.wdata;              // [RQ12]
        end
        if (!shadow_on && !(host_req.write && !widx[5]))
            next_state.shadow = next_state.live;
        if (host_req.read)
        begin
            next_state.rvalid = 1'b1;
            next_state.rdata = widx[5] ? 8'h00 : state.shadow[widx[4:0]];
        end
        r = next_state.live;
        next_state.ctrl.bars_on =
            !r[decode(sd_enc_pkg::ADDR_TEST_PATTERN)][sd_enc_pkg::B_BARS_OFF];   // [RQ1]
        next_state.ctrl.burst_on =
            !r[decode(sd_enc_pkg::ADDR_TEST_PATTERN)][sd_enc_pkg::B_BURST_OFF];  // [RQ2]
        next_state.ctrl.chroma_pass =
            !r[decode(sd_enc_pkg::ADDR_TEST_PATTERN)][sd_enc_pkg::B_CHROMA_OFF]; // [RQ3]
        code = r[decode(sd_enc_pkg::ADDR_STANDARD)][sd_enc_pkg::B_STD_LO +: 2];
        next_state.ctrl.sd_standard_select = sd_enc_pkg::standard_t'(code);     // [RQ23]
        next_state.ctrl.prpb_level_select = sd_enc_pkg::prpb_level_t'(
            r[decode(sd_enc_pkg::ADDR_LEVEL_CONTROL)][sd_enc_pkg::B_PRPB_LO +: 2]); // [RQ4]
        next_state.ctrl.prpb_ntsc_large = (code == 2'b00);                      // [RQ4]
        next_state.ctrl.luma_level_select =
            r[decode(sd_enc_pkg::ADDR_LEVEL_CONTROL)][sd_enc_pkg::B_LUMA_LEVEL]; // [RQ5]
        next_state.ctrl.component_pedestal_on =
            r[decode(sd_enc_pkg::ADDR_LEVEL_CONTROL)][sd_enc_pkg::B_COMP_PED];   // [RQ6]
        if (!r[decode(sd_enc_pkg::ADDR_LINE_TIMING)][sd_enc_pkg::B_LINE_LEN])
            next_state.ctrl.active_pixels = sd_enc_pkg::PIX_FULL;             // [RQ7]
        else if (code == 2'b00)
            next_state.ctrl.active_pixels = sd_enc_pkg::PIX_NTSC;             // [RQ7]
        else
            next_state.ctrl.active_pixels = sd_enc_pkg::PIX_PAL;              // [RQ7]
        next_state.ctrl.lock_enabled = state.lock_sync[1] &&
            (r[decode(sd_enc_pkg::ADDR_LINE_TIMING)][sd_enc_pkg::B_LOCK_LO +: 2]
            == 2'b11);                                                           // [RQ8]
        next_state.ctrl.counter_free_run =
            r[decode(sd_enc_pkg::ADDR_COUNTER_SYNC)][sd_enc_pkg::B_FREE_RUN];    // [RQ9]
        code = r[decode(sd_enc_pkg::ADDR_COUNTER_SYNC)][sd_enc_pkg::B_BURST_LO +: 2];
        next_state.ctrl.burst_reserved = (code == 2'b11);                        // [RQ10]
        unique case (code)
            2'b00: next_state.ctrl.burst_delay_cycles = sd_enc_pkg::BURST0_CYC;  // [RQ10]
            2'b01: next_state.ctrl.burst_delay_cycles = sd_enc_pkg::BURST1_CYC;
            2'b10: next_state.ctrl.burst_delay_cycles = sd_enc_pkg::BURST2_CYC;
            2'b11: next_state.ctrl.burst_delay_cycles = sd_enc_pkg::BURST0_CYC;
        endcase
        next_state.ctrl.gamma_apply =
            r[decode(sd_enc_pkg::ADDR_GAMMA_BUFFER)][sd_enc_pkg::B_GAMMA_EN];    // [RQ11]
        next_state.ctrl.gamma_use_b = next_state.ctrl.gamma_apply &&
            r[decode(sd_enc_pkg::ADDR_GAMMA_BUFFER)][sd_enc_pkg::B_GAMMA_B];     // [RQ11]
        next_state.ctrl.chroma_delay_reserved =
            (r[decode(sd_enc_pkg::ADDR_DELAY_LIMITER)][sd_enc_pkg::B_CDLY_LO +: 2] == 2'b11);
        next_state.ctrl.undershoot_clamp_select = sd_enc_pkg::clamp_t'(
            r[decode(sd_enc_pkg::ADDR_DELAY_LIMITER)][sd_enc_pkg::B_UNDER_LO +: 2]); // [RQ15]
        next_state.ctrl.luma_floor_select =
            r[decode(sd_enc_pkg::ADDR_LUMA_MIN_DELAY)][sd_enc_pkg::B_LUMA_FLOOR]; // [RQ16]
        next_state.ctrl.subcarrier_frequency_word = {
            pick(r, sd_enc_pkg::ADDR_FREQ_WORD0 + 16'h0003),
            pick(r, sd_enc_pkg::ADDR_FREQ_WORD0 + 16'h0002),
            pick(r, sd_enc_pkg::ADDR_FREQ_WORD0 + 16'h0001),
            pick(r, sd_enc_pkg::ADDR_FREQ_WORD0)};                              // [RQ17]
        next_state.ctrl.subcarrier_phase = {2'b00, pick(r, sd_enc_pkg::ADDR_PHASE)};
        next_state.ctrl.caption_even_on =
            r[decode(sd_enc_pkg::ADDR_CAPTION_VBI)][sd_enc_pkg::B_CAP_EVEN];     // [RQ19]
        next_state.ctrl.caption_odd_on =
            r[decode(sd_enc_pkg::ADDR_CAPTION_VBI)][sd_enc_pkg::B_CAP_ODD];      // [RQ19]
        next_state.ctrl.blanking_data_accept =
            r[decode(sd_enc_pkg::ADDR_CAPTION_VBI)][sd_enc_pkg::B_VBI_ACCEPT];   // [RQ20]
        next_state.ctrl.caption_extended_even = {
            pick(r, sd_enc_pkg::ADDR_EXT_EVEN0 + 16'h0001),
            pick(r, sd_enc_pkg::ADDR_EXT_EVEN0)};                               // [RQ21]
        next_state.ctrl.caption_extended_odd = {
            pick(r, sd_enc_pkg::ADDR_EXT_ODD0 + 16'h0001),
            pick(r, sd_enc_pkg::ADDR_EXT_ODD0)};                                // [RQ21]
        next_state.ctrl.pedestal_line17_odd  = pick(r, sd_enc_pkg::ADDR_PED_L17_ODD);  // [RQ18]
        next_state.ctrl.pedestal_line25_odd  = pick(r, sd_enc_pkg::ADDR_PED_L25_ODD);  // [RQ18]
        next_state.ctrl.pedestal_line17_even = pick(r, sd_enc_pkg::ADDR_PED_L17_EVEN); // [RQ18]
        next_state.ctrl.pedestal_line25_even = pick(r, sd_enc_pkg::ADDR_PED_L25_EVEN); // [RQ18]
        next_state.ctrl.standard_autodetect_on =
            r[decode(sd_enc_pkg::ADDR_PROC_ENABLES)][sd_enc_pkg::B_AUTODETECT];  // [RQ22]
    end

    // State register; reset loads the documented defaults
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state        <= '0;
            state.live   <= reset_image();                                      // [RQ24]
            state.shadow <= reset_image();                                      // [RQ24]
            state.ctrl.burst_on    <= 1'b1;
            state.ctrl.bars_on     <= 1'b1;
            state.ctrl.chroma_pass <= 1'b1;
            state.ctrl.active_pixels <= sd_enc_pkg::PIX_FULL;
            state.ctrl.burst_delay_cycles <= sd_enc_pkg::BURST0_CYC;
            state.ctrl.luma_floor_select <= 1'b1;
            state.ctrl.blanking_data_accept <= 1'b0;
            state.ctrl.prpb_level_select <= sd_enc_pkg::PRPB_700;
            state.ctrl.prpb_ntsc_large <= 1'b1;
            state.ctrl.caption_even_on <= 1'b0;
            state.ctrl.counter_free_run <= 1'b1;
        end
        else
            state <= next_state;
    end

    // Delay taps: chroma in steps of four, luma in steps of two
    always_comb
    begin
        unique case (state.live[decode(sd_enc_pkg::ADDR_DELAY_LIMITER)][1:0])
            2'b00: chroma_tap = 4'd0;                                          // [RQ13]
            2'b01: chroma_tap = 4'(sd_enc_pkg::CDLY_STEP);                      // [RQ13]
            2'b10: chroma_tap = 4'(2 * sd_enc_pkg::CDLY_STEP);                  // [RQ13]
            2'b11: chroma_tap = 4'd0;
        endcase
        unique case (state.live[decode(sd_enc_pkg::ADDR_LUMA_MIN_DELAY)][1:0])
            2'b00: luma_tap = 4'd0;                                            // [RQ14]
            2'b01: luma_tap = 4'(sd_enc_pkg::YDLY_STEP);                        // [RQ14]
            2'b10: luma_tap = 4'(2 * sd_enc_pkg::YDLY_STEP);                    // [RQ14]
            2'b11: luma_tap = 4'(3 * sd_enc_pkg::YDLY_STEP);                    // [RQ14]
        endcase
    end

    // Shared delay structure for both channels
    sample_delay luma_delay
    (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .din     (luma_in),
        .tap     (luma_tap),
        .dout    (luma_out)
    );

    sample_delay chroma_delay
    (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .din     (chroma_in),
        .tap     (chroma_tap),
        .dout    (chroma_out)
    );

    assign host_rdata  = state.rdata;
    assign host_rvalid = state.rvalid;
    assign control     = state.ctrl;

    // Checks on decoded controls, lock, shadow apply and chroma tap
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    bars_polarity_a: assert property ( // [RQ1]
        control.bars_on != state.live[decode(sd_enc_pkg::ADDR_TEST_PATTERN)][2])
        else $error("bars polarity wrong");
    burst_polarity_a: assert property ( // [RQ2]
        control.burst_on != state.live[decode(sd_enc_pkg::ADDR_TEST_PATTERN)][1])
        else $error("burst polarity wrong");
    chroma_remove_a: assert property ( // [RQ3]
        control.chroma_pass != state.live[decode(sd_enc_pkg::ADDR_TEST_PATTERN)][0])
        else $error("chroma pass wrong");
    lock_pin_a: assert property ( // [RQ8]
        control.lock_enabled |-> $past(state.lock_sync[1]))
        else $error("lock without pin");
    frame_apply_a: assert property ( // [RQ12]
        frame_update && !host_req.write |=> state.live == $past(state.shadow))
        else $error("shadow not applied");
    chroma_tap_a: assert property ( // [RQ13]
        chroma_tap inside {4'd0, 4'd4, 4'd8})
        else $error("chroma tap illegal");
endmodule // sd_video_encoder_control

// File: include/sd_enc_pkg.sv
// Package: register map, field positions and reset values for the SD encoder control bank
package sd_enc_pkg;
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned REG_N    = 26;
    localparam int unsigned IDX_W    = 5;

    // Byte addresses
    localparam logic [15:0] ADDR_OUTPUT_MODE_A   = 16'he4_83;
    localparam logic [15:0] ADDR_LINE_TIMING     = 16'he4_84;
    localparam logic [15:0] ADDR_LEVEL_CONTROL   = 16'he4_85;
    localparam logic [15:0] ADDR_COUNTER_SYNC    = 16'he4_86;
    localparam logic [15:0] ADDR_PROC_ENABLES    = 16'he4_87;
    localparam logic [15:0] ADDR_GAMMA_BUFFER    = 16'he4_88;
    localparam logic [15:0] ADDR_DELAY_LIMITER   = 16'he4_89;
    localparam logic [15:0] ADDR_LUMA_MIN_DELAY  = 16'he4_8a;
    localparam logic [15:0] ADDR_CAPTION_VBI     = 16'he4_8b;
    localparam logic [15:0] ADDR_FREQ_WORD0      = 16'he4_8c;
    localparam logic [15:0] ADDR_PHASE           = 16'he4_90;
    localparam logic [15:0] ADDR_EXT_EVEN0       = 16'he4_91;
    localparam logic [15:0] ADDR_EXT_ODD0        = 16'he4_93;
    localparam logic [15:0] ADDR_PED_L17_ODD     = 16'he4_95;
    localparam logic [15:0] ADDR_PED_L25_ODD     = 16'he4_96;
    localparam logic [15:0] ADDR_PED_L17_EVEN    = 16'he4_97;
    localparam logic [15:0] ADDR_PED_L25_EVEN    = 16'he4_98;
    localparam logic [15:0] ADDR_TEST_PATTERN    = 16'he4_99;
    localparam logic [15:0] ADDR_STANDARD        = 16'he4_9a;
    localparam logic [15:0] ADDR_FIRST           = 16'he4_83;
    localparam logic [15:0] ADDR_LAST            = 16'he4_9a;

    // Reset values
    localparam logic [7:0] RST_OUTPUT_MODE_A  = 8'h09;
    localparam logic [7:0] RST_LINE_TIMING    = 8'h00;
    localparam logic [7:0] RST_LEVEL_CONTROL  = 8'h04;
    localparam logic [7:0] RST_COUNTER_SYNC   = 8'h02;
    localparam logic [7:0] RST_LUMA_MIN_DELAY = 8'h08;
    localparam logic [7:0] RST_CAPTION_VBI    = 8'h08;
    localparam logic [31:0] RST_FREQ_WORD     = 32'h0000_0000;
    localparam logic [7:0] RST_ZERO           = 8'h00;

    // Field positions
    localparam int unsigned B_COMP_PED     = 0;   // level control
    localparam int unsigned B_LUMA_LEVEL   = 1;
    localparam int unsigned B_PRPB_LO      = 2;
    localparam int unsigned B_CAP_ODD      = 0;   // caption/vbi control
    localparam int unsigned B_CAP_EVEN     = 1;
    localparam int unsigned B_VBI_ACCEPT   = 2;
    localparam int unsigned B_CHROMA_OFF   = 0;   // test pattern control
    localparam int unsigned B_BURST_OFF    = 1;
    localparam int unsigned B_BARS_OFF     = 2;
    localparam int unsigned B_LINE_LEN     = 0;   // line timing
    localparam int unsigned B_LOCK_LO      = 1;
    localparam int unsigned B_FREE_RUN     = 1;   // counter sync
    localparam int unsigned B_BURST_LO     = 3;
    localparam int unsigned B_AUTODETECT   = 6;   // processing enables
    localparam int unsigned B_GAMMA_EN     = 1;   // gamma/buffer
    localparam int unsigned B_GAMMA_B      = 0;
    localparam int unsigned B_SHADOW_ON    = 2;
    localparam int unsigned B_CDLY_LO      = 0;   // delay/limiter
    localparam int unsigned B_UNDER_LO     = 4;
    localparam int unsigned B_YDLY_LO      = 0;   // luma min/delay
    localparam int unsigned B_LUMA_FLOOR   = 3;
    localparam int unsigned B_STD_LO       = 0;   // standard select

    // Delay line reach in clocks
    localparam int unsigned CDLY_STEP      = 4;
    localparam int unsigned YDLY_STEP      = 2;
    localparam int unsigned DLY_DEPTH      = 9;

    // Burst position figures and clock rate
    localparam real CLK_MHZ     = 20.0;
    localparam real BURST0_US   = 5.17;
    localparam real BURST1_US   = 5.31;
    localparam real BURST2_US   = 5.59;
    localparam logic [7:0] BURST0_CYC = 8'(int'($floor(BURST0_US * CLK_MHZ)));
    localparam logic [7:0] BURST1_CYC = 8'(int'($floor(BURST1_US * CLK_MHZ)));
    localparam logic [7:0] BURST2_CYC = 8'(int'($floor(BURST2_US * CLK_MHZ)));

    // Active pixel counts
    localparam logic [9:0] PIX_FULL = 10'h2d0;   // 720
    localparam logic [9:0] PIX_NTSC = 10'h2c6;   // 710
    localparam logic [9:0] PIX_PAL  = 10'h2be;   // 702

    typedef enum logic [1:0] {STD_NTSC, STD_PAL_BDGHI, STD_PAL_M, STD_PAL_N} standard_t;
    typedef enum logic [1:0] {PRPB_STD, PRPB_700, PRPB_1000, PRPB_648} prpb_level_t;
    typedef enum logic [1:0] {CLAMP_OFF, CLAMP_M11, CLAMP_M6, CLAMP_M1P5} clamp_t;

    // Decoded controls handed to the video path
    typedef struct packed {
        logic        bars_on;
        logic        burst_on;
        logic        chroma_pass;
        prpb_level_t prpb_level_select;
        logic        prpb_ntsc_large;
        logic        luma_level_select;
        logic        component_pedestal_on;
        logic [9:0]  active_pixels;
        logic        lock_enabled;
        logic        counter_free_run;
        logic [7:0]  burst_delay_cycles;
        logic        burst_reserved;
        logic        gamma_use_b;
        logic        gamma_apply;
        logic        chroma_delay_reserved;
        clamp_t      undershoot_clamp_select;
        logic        luma_floor_select;
        logic [31:0] subcarrier_frequency_word;
        logic [9:0]  subcarrier_phase;
        logic        caption_even_on;
        logic        caption_odd_on;
        logic        blanking_data_accept;
        logic [15:0] caption_extended_even;
        logic [15:0] caption_extended_odd;
        logic [7:0]  pedestal_line17_odd;
        logic [7:0]  pedestal_line25_odd;
        logic [7:0]  pedestal_line17_even;
        logic [7:0]  pedestal_line25_even;
        logic        standard_autodetect_on;
        standard_t   sd_standard_select;
    } control_t;

    // Control port request
    typedef struct packed {
        logic        write;
        logic        read;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } host_req_t;
endpackage

// File: logic/sample_delay.sv
// Tapped sample delay line with registered selectable output
`timescale 1ns/10ps
module sample_delay
(
    input  wire logic                                    ref_clk,
    input  wire logic                                    reset_n,
    input  wire logic [9:0]                              din,
    input  wire logic [$clog2(sd_enc_pkg::DLY_DEPTH)-1:0] tap,
    output logic      [9:0]                              dout
);
    typedef struct packed {
        logic [sd_enc_pkg::DLY_DEPTH-1:0][9:0] line;
        logic [9:0]                            out;
    } delay_state_t;

    delay_state_t state;
    delay_state_t next_state;

    // Shift line; tap 0 passes the input with only the output register
    always_comb
    begin
        next_state = state;
        next_state.line = {state.line[sd_enc_pkg::DLY_DEPTH-2:0], din};
        next_state.out = (tap == '0) ? din : state.line[tap - 1'b1];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign dout = state.out;
endmodule // sample_delay

// File: verification/sd_video_encoder_control_bench.sv
// Self-checking bench for the SD encoder control register bank
`timescale 1ns/10ps
module sd_video_encoder_control_bench;
    localparam int LIMIT = 3000;
    logic                  ref_clk = 1'b0;
    logic                  reset_n = 1'b0;
    sd_enc_pkg::host_req_t host_req = '0;
    logic                  frame_update = 1'b0;
    logic                  subcarrier_lock_pin = 1'b0;
    logic [9:0]            luma_in = 10'h000;
    logic [9:0]            chroma_in = 10'h000;
    logic [7:0]            host_rdata;
    logic                  host_rvalid;
    sd_enc_pkg::control_t  control;
    logic [9:0]            luma_out;
    logic [9:0]            chroma_out;
    int                    errors = 0;
    int                    total_checks = 0;
    int                    cycles = 0;
    logic [15:0] def_addr [10] = '{16'he4_83, 16'he4_84, 16'he4_85, 16'he4_86, 16'he4_87,
                                   16'he4_88, 16'he4_89, 16'he4_8a, 16'he4_8b, 16'he4_99};
    logic [7:0]  def_val [10]  = '{8'h09, 8'h00, 8'h04, 8'h02, 8'h00,
                                   8'h00, 8'h00, 8'h08, 8'h08, 8'h00};

    sd_video_encoder_control DUT
    (
        .ref_clk             (ref_clk),
        .reset_n             (reset_n),
        .host_req            (host_req),
        .frame_update        (frame_update),
        .subcarrier_lock_pin (subcarrier_lock_pin),
        .luma_in             (luma_in),
        .chroma_in           (chroma_in),
        .host_rdata          (host_rdata),
        .host_rvalid         (host_rvalid),
        .control             (control),
        .luma_out            (luma_out),
        .chroma_out          (chroma_out)
    );

    // Clock
    always #25 ref_clk = ~ref_clk;

    // Ramp samples and watchdog
    always @(posedge ref_clk)
    begin
        luma_in   <= luma_in + 10'h001;
        chroma_in <= chroma_in + 10'h001;
        cycles    <= cycles + 1;
        if (cycles == LIMIT)
        begin
            errors = errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write pulse, then idle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        host_req <= '0;
    endtask

    // Read pulse; answer looked at in its one valid cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        host_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        host_req <= '0;
        #1;
        chk(32'(host_rvalid), 32'h0000_0001);
        chk(32'(host_rdata), 32'(e));
    endtask

    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic test_defaults();
        for (int i = 0; i < 10; i++) rd(def_addr[i], def_val[i]);
        rd(16'he4_00, 8'h00);
        chk(32'(control.bars_on), 32'h0000_0001);
        chk(32'(control.burst_on), 32'h0000_0001);
        chk(32'(control.chroma_pass), 32'h0000_0001);
        chk(32'(control.burst_delay_cycles), 32'h0000_0067);
        chk(32'(control.counter_free_run), 32'h0000_0001);
        chk(32'(control.blanking_data_accept), 32'h0000_0000);
        $display("defaults test done");
    endtask

    task automatic test_patterns();
        wr(sd_enc_pkg::ADDR_TEST_PATTERN, 8'h07);
        settle();
        chk(32'(control.bars_on), 32'h0000_0000);
        chk(32'(control.burst_on), 32'h0000_0000);
        chk(32'(control.chroma_pass), 32'h0000_0000);
        rd(sd_enc_pkg::ADDR_TEST_PATTERN, 8'h07);
        $display("pattern test done");
    endtask

    task automatic test_std_lock();
        subcarrier_lock_pin <= 1'b1;
        wr(sd_enc_pkg::ADDR_LINE_TIMING, 8'h07);
        wr(sd_enc_pkg::ADDR_STANDARD, 8'h00);
        settle();
        chk(32'(control.active_pixels), 32'h0000_02c6);
        chk(32'(control.lock_enabled), 32'h0000_0001);
        wr(sd_enc_pkg::ADDR_LINE_TIMING, 8'h01);
        wr(sd_enc_pkg::ADDR_STANDARD, 8'h01);
        settle();
        chk(32'(control.active_pixels), 32'h0000_02be);
        chk(32'(control.lock_enabled), 32'h0000_0000);
        for (int k = 0; k < 4; k++)
        begin
            wr(sd_enc_pkg::ADDR_STANDARD, 8'(k));
            wr(sd_enc_pkg::ADDR_LEVEL_CONTROL, 8'(k * 4));
            settle();
            chk(32'(control.sd_standard_select), 32'(k));
            chk(32'(control.prpb_level_select), 32'(k));
        end
        wr(sd_enc_pkg::ADDR_LINE_TIMING, 8'h00);
        settle();
        chk(32'(control.active_pixels), 32'h0000_02d0);
        $display("standard and lock test done");
    endtask

    task automatic test_freq_word();
        wr(sd_enc_pkg::ADDR_FREQ_WORD0, 8'h21);
        wr(16'he4_8d, 8'hf0);
        wr(16'he4_8e, 8'h7c);
        wr(16'he4_8f, 8'h1f);
        settle();
        chk(control.subcarrier_frequency_word, 32'h1f7c_f021);
        $display("frequency word test done");
    endtask

    task automatic test_delays();
        logic [9:0] by;
        logic [9:0] bc;
        for (int k = 0; k < 4; k++)
        begin
            wr(sd_enc_pkg::ADDR_LUMA_MIN_DELAY, 8'h08 | 8'(k));
            wr(sd_enc_pkg::ADDR_DELAY_LIMITER, (k < 3) ? 8'(k * 17) : 8'h30);
            repeat (12) @(posedge ref_clk);
            #1;
            if (k == 0)
            begin
                by = luma_in - luma_out;
                bc = chroma_in - chroma_out;
            end
            chk(32'(10'(luma_in - luma_out - by)), 32'(2 * k));
            chk(32'(10'(chroma_in - chroma_out - bc)), (k < 3) ? 32'(4 * k) : 32'h0);
            chk(32'(control.undershoot_clamp_select), 32'(k));
            chk(32'(control.luma_floor_select), 32'h0000_0001);
        end
        $display("delay test done");
    endtask

    task automatic test_shadow();
        wr(sd_enc_pkg::ADDR_GAMMA_BUFFER, 8'h04);
        wr(sd_enc_pkg::ADDR_LEVEL_CONTROL, 8'h07);
        settle();
        chk(32'(control.component_pedestal_on), 32'h0000_0000);
        rd(sd_enc_pkg::ADDR_LEVEL_CONTROL, 8'h07);
        @(posedge ref_clk);
        frame_update <= 1'b1;
        @(posedge ref_clk);
        frame_update <= 1'b0;
        settle();
        chk(32'(control.component_pedestal_on), 32'h0000_0001);
        chk(32'(control.luma_level_select), 32'h0000_0001);
        wr(sd_enc_pkg::ADDR_GAMMA_BUFFER, 8'h00);
        $display("shadow test done");
    endtask

    task automatic test_misc();
        wr(sd_enc_pkg::ADDR_GAMMA_BUFFER, 8'h01);
        wr(sd_enc_pkg::ADDR_COUNTER_SYNC, 8'h10);
        wr(sd_enc_pkg::ADDR_CAPTION_VBI, 8'h07);
        wr(sd_enc_pkg::ADDR_PROC_ENABLES, 8'h40);
        wr(sd_enc_pkg::ADDR_PED_L25_EVEN, 8'ha5);
        wr(16'he4_92, 8'h3c);
        settle();
        chk(32'(control.gamma_use_b), 32'h0000_0000);
        chk(32'(control.counter_free_run), 32'h0000_0000);
        chk(32'(control.burst_delay_cycles), 32'h0000_006f);
        chk(32'(control.caption_even_on), 32'h0000_0001);
        chk(32'(control.caption_odd_on), 32'h0000_0001);
        chk(32'(control.blanking_data_accept), 32'h0000_0001);
        chk(32'(control.standard_autodetect_on), 32'h0000_0001);
        chk(32'(control.pedestal_line25_even), 32'h0000_00a5);
        chk(32'(control.caption_extended_even), 32'h0000_3c00);
        wr(sd_enc_pkg::ADDR_GAMMA_BUFFER, 8'h03);
        settle();
        chk(32'(control.gamma_use_b), 32'h0000_0001);
        $display("misc test done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        test_defaults();
        test_patterns();
        test_std_lock();
        test_freq_word();
        test_delays();
        test_shadow();
        test_misc();
        close_out();
    end
endmodule // sd_video_encoder_control_bench
